/* File: rtl/dual_watchdog.sv */
// Hardware watchdog and counter-array module 4 watchdog
//
// Overview of operation
// - After any reset the hardware watchdog is off and does not count.
// - Writing 1e then e1 to the service register arms the watchdog.
// - Armed counter advances once per machine cycle.
// - Once armed, only a reset disarms the hardware watchdog.
// - 14-bit counter reaching 3fff resets the whole device.
// - Service register is write-only; the counter is never visible.
// - Overflow drives reset pin high for 98 or 196 oscillator periods.
// - Only module 4 offers the watchdog; other modes stay usable.
// - Active array watchdog compares 16-bit value with timer; match resets.
// - Array watchdog reset never drives the reset pin.
// - Array watchdog active only in compare mode with match-reset enable set.
// - Clearing the enable before a match suppresses the reset.
// - Match detected only with comparator and match enables both set.
`timescale 1ns/100ps
`default_nettype none
module dual_watchdog (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        twelveClkMode,
  input  wire logic        regWrite,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic [7:0]  array_counter_mode_reg,
  input  wire logic [7:0]  module4_mode_reg,
  input  wire logic [7:0]  module4_compare_low,
  input  wire logic [7:0]  module4_compare_high,
  input  wire logic [7:0]  array_timer_low,
  input  wire logic [7:0]  array_timer_high,
  output logic             resetPinOut,
  output logic             internalReset,
  output logic             hwArmed
);
  mcycle_if mc ();
  assign mc.twelveClk = twelveClkMode;

  mcycle_gen u_gen (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .mc      (mc)
  );

  // Any watchdog reset loops back as a device reset
  logic devRstn;
  logic hwOverflow_q;
  logic arrayReset_q;
  assign devRstn = rstn && !hwOverflow_q && !arrayReset_q;

  wdog_pkg::arm_state_t arm_q;
  logic                 armed_q;
  logic [13:0]          cnt_q;

  logic svcWrite;
  logic seqDone;
  assign svcWrite = regWrite && (regAddr == wdog_pkg::SERVICE_REG_ADDR);
  assign seqDone  = svcWrite && (arm_q == wdog_pkg::ARM_FIRST)
                    && (regWdata == wdog_pkg::ARM_BYTE_SECOND);

  // Sequence tracker: a repeated 1e keeps the pair open; any byte other than 1e or e1 breaks it
  always_ff @(posedge ref_clk) begin
    if (!devRstn) begin
      arm_q <= wdog_pkg::ARM_IDLE;
    end else if (svcWrite) begin
      unique case (arm_q)
        wdog_pkg::ARM_IDLE:
          arm_q <= (regWdata == wdog_pkg::ARM_BYTE_FIRST) ? wdog_pkg::ARM_FIRST
                                                          : wdog_pkg::ARM_IDLE;
        wdog_pkg::ARM_FIRST:
          arm_q <= (regWdata == wdog_pkg::ARM_BYTE_FIRST) ? wdog_pkg::ARM_FIRST
                                                          : wdog_pkg::ARM_IDLE;
        default: arm_q <= wdog_pkg::ARM_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!devRstn) armed_q <= 1'b0;
    else if (seqDone) armed_q <= 1'b1;
  end

  logic hwHit;
  // A service landing on the last tick restarts the count instead of firing
  assign hwHit = armed_q && mc.tick && !seqDone
                 && (cnt_q == wdog_pkg::HW_COUNT_LAST - 14'h1);

  always_ff @(posedge ref_clk) begin
    if (!devRstn) cnt_q <= 14'h0000;
    else if (seqDone) cnt_q <= 14'h0000;
    else if (armed_q && mc.tick) cnt_q <= cnt_q + 14'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (!devRstn) hwOverflow_q <= 1'b0;
    else hwOverflow_q <= hwHit;
  end

  // Array watchdog: comparator plus match enables, no PWM, reset-enable bit
  logic compareMode;
  logic arrayActive;
  logic arrayMatch;
  assign compareMode = module4_mode_reg[wdog_pkg::COMPARATOR_EN_BIT]
                       && module4_mode_reg[wdog_pkg::MATCH_EN_BIT]
                       && !module4_mode_reg[wdog_pkg::PWM_BIT];
  assign arrayActive = compareMode
                       && array_counter_mode_reg[wdog_pkg::MATCH_RESET_BIT];
  assign arrayMatch  = arrayActive
                       && ({module4_compare_high, module4_compare_low}
                           == {array_timer_high, array_timer_low});

  always_ff @(posedge ref_clk) begin
    if (!devRstn) arrayReset_q <= 1'b0;
    else arrayReset_q <= arrayMatch;
  end

  // Pin pulse only from the hardware watchdog
  logic pulse;
  reset_pulse u_pulse (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .fire    (hwOverflow_q),
    .mc      (mc),
    .pulse   (pulse)
  );

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      resetPinOut   <= 1'b0;
      internalReset <= 1'b0;
      hwArmed       <= 1'b0;
    end else begin
      resetPinOut   <= pulse;
      internalReset <= hwOverflow_q || arrayReset_q;
      hwArmed       <= armed_q;
    end
  end

  hw_count_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !armed_q |=> cnt_q == 14'h0000) else $error("counter moved while disarmed");
  arm_seq_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    seqDone && devRstn |=> armed_q && cnt_q == 14'h0000) else $error("sequence did not arm");
  stay_on_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    armed_q && devRstn |=> armed_q || !devRstn) else $error("watchdog disarmed");
  ovf_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwHit |=> hwOverflow_q) else $error("overflow missed");
  pin_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    hwOverflow_q |=> ##2 resetPinOut [*8]) else $error("reset pin pulse short");
  arr_pin_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    arrayReset_q && !pulse |=> !resetPinOut) else $error("array reset drove pin");
  arr_match_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    arrayMatch && devRstn |=> arrayReset_q ##1 internalReset) else $error("match no reset");
  arr_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !arrayActive |=> !arrayReset_q) else $error("reset without enable");
  step_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    armed_q && mc.tick && !seqDone && !hwHit && devRstn |=> cnt_q == $past(cnt_q) + 14'h1)
    else $error("counter did not step");
endmodule
`default_nettype wire

/* File: inc/wdog_pkg.sv */
// Constants and types shared by the dual watchdog design
package wdog_pkg;
  localparam logic [7:0]  SERVICE_REG_ADDR  = 8'ha6;
  localparam logic [7:0]  ARM_BYTE_FIRST    = 8'h1e;
  localparam logic [7:0]  ARM_BYTE_SECOND   = 8'he1;
  localparam int          HW_COUNT_WIDTH    = 14;
  localparam logic [13:0] HW_COUNT_LAST     = 14'h3fff;
  localparam int          PULSE_OSC_SIX     = 98;
  localparam int          PULSE_OSC_TWELVE  = 196;
  localparam int          CLOCKS_SIX        = 6;
  localparam int          CLOCKS_TWELVE     = 12;
  // Counter mode register bit that enables reset on module 4 match
  localparam int          MATCH_RESET_BIT   = 6;
  localparam logic [7:0]  COUNTER_MODE_RESET = 8'h00;
  localparam logic [7:0]  MODULE_MODE_RESET = 8'h00;
  // Module mode register field positions
  localparam int          COMPARATOR_EN_BIT = 6;
  localparam int          MATCH_EN_BIT      = 3;
  localparam int          PWM_BIT           = 1;
  localparam int          CAPTURE_POS_BIT   = 5;
  localparam int          CAPTURE_NEG_BIT   = 4;
  typedef enum logic [1:0] {
    ARM_IDLE  = 2'b00,
    ARM_FIRST = 2'b01
  } arm_state_t;
endpackage

/* File: inc/mcycle_if.sv */
// Machine-cycle timing shared between the top and its helpers
`timescale 1ns/100ps
`default_nettype none
interface mcycle_if;
  logic tick;
  logic twelveClk;
  modport src (output tick, input twelveClk);
  modport dst (input tick, input twelveClk);
endinterface
`default_nettype wire

/* File: rtl/mcycle_gen.sv */
// Machine-cycle tick generator, six or twelve oscillator clocks per cycle
`timescale 1ns/100ps
`default_nettype none
module mcycle_gen (
  input  wire logic ref_clk,
  input  wire logic rstn,
  mcycle_if.src     mc
);
  logic [3:0] div_q;
  logic [3:0] last;
  assign last = mc.twelveClk ? 4'(wdog_pkg::CLOCKS_TWELVE - 1) : 4'(wdog_pkg::CLOCKS_SIX - 1);
  always_ff @(posedge ref_clk) begin
    if (!rstn) div_q <= 4'h0;
    else if (div_q >= last) div_q <= 4'h0;
    else div_q <= div_q + 4'h1;
  end
  assign mc.tick = (div_q >= last);
endmodule
`default_nettype wire

/* File: rtl/reset_pulse.sv */
// Fixed-length pulse stretcher for the reset-out pin
`timescale 1ns/100ps
`default_nettype none
module reset_pulse (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic fire,
  mcycle_if.dst     mc,
  output var  logic pulse
);
  logic [7:0] cnt_q;
  logic [7:0] len;
  assign len = mc.twelveClk ? 8'(wdog_pkg::PULSE_OSC_TWELVE) : 8'(wdog_pkg::PULSE_OSC_SIX);
  always_ff @(posedge ref_clk) begin
    if (!rstn) cnt_q <= 8'h00;
    else if (fire) cnt_q <= len;
    else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
  end
  assign pulse = (cnt_q != 8'h00);
endmodule
`default_nettype wire

/* File: tb/dual_watchdog_reset_logic_tb_top.sv */
// Self-checking bench for the dual watchdog block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module dual_watchdog_reset_logic_tb_top;
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       twelveClkMode = 1'b0;
  logic       regWrite = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] array_counter_mode_reg = 8'h00;
  logic [7:0] module4_mode_reg = 8'h00;
  logic [7:0] module4_compare_low = 8'h00;
  logic [7:0] module4_compare_high = 8'h00;
  logic [7:0] array_timer_low = 8'h01;
  logic [7:0] array_timer_high = 8'h00;
  logic       resetPinOut;
  logic       internalReset;
  logic       hwArmed;
  int         fails = 0;
  int         n_compared = 0;
  int         seed = 32'h8f8e;
  int         n;
  logic [7:0] modes[$] = '{8'h48, 8'h4c, 8'h40, 8'h08, 8'h4a, 8'h48, 8'h48};
  logic [7:0] cmods[$] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h00, 8'h40};

  always #4 ref_clk = ~ref_clk;

  dual_watchdog uut (.ref_clk(ref_clk), .rstn(rstn), .twelveClkMode(twelveClkMode),
    .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
    .array_counter_mode_reg(array_counter_mode_reg), .module4_mode_reg(module4_mode_reg),
    .module4_compare_low(module4_compare_low), .module4_compare_high(module4_compare_high),
    .array_timer_low(array_timer_low), .array_timer_high(array_timer_high),
    .resetPinOut(resetPinOut), .internalReset(internalReset), .hwArmed(hwArmed));

  // Reference model of when the module 4 match resets the device
  function automatic logic array_fires(logic [7:0] md, logic [7:0] cm);
    return md[wdog_pkg::COMPARATOR_EN_BIT] & md[wdog_pkg::MATCH_EN_BIT]
      & ~md[wdog_pkg::PWM_BIT] & cm[wdog_pkg::MATCH_RESET_BIT];
  endfunction

  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Idle cycle after each write so the strobe is never set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge ref_clk);
    regWrite = 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic array_case(input logic [7:0] md, input logic [7:0] cm);
    logic [15:0] cmp;
    logic        seen;
    logic        pin;
    cmp = 16'($random(seed));
    seen = 1'b0;
    pin = 1'b0;
    module4_mode_reg = md;
    array_counter_mode_reg = cm;
    module4_compare_low = cmp[7:0];
    module4_compare_high = cmp[15:8];
    {array_timer_high, array_timer_low} = cmp ^ 16'h0100;
    repeat (4) begin @(negedge ref_clk); seen |= internalReset; end
    `CHK(seen, 1'b0, "reset on high byte mismatch")
    {array_timer_high, array_timer_low} = cmp;
    repeat (4) begin @(negedge ref_clk); seen |= internalReset; pin |= resetPinOut; end
    `CHK(seen, array_fires(md, cm), "array match reset")
    `CHK(pin, 1'b0, "reset pin driven by array match")
    {array_timer_high, array_timer_low} = cmp ^ 16'h0001;
    module4_compare_high = cmp[15:8] + 8'h01;
    repeat (4) @(negedge ref_clk);
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    `CHK({resetPinOut, internalReset, hwArmed}, 3'b000, "outputs after reset")
    foreach (modes[i]) array_case(modes[i], cmods[i]);
    $display("test array watchdog done");
    wr(8'ha5, wdog_pkg::ARM_BYTE_FIRST);
    wr(wdog_pkg::SERVICE_REG_ADDR, wdog_pkg::ARM_BYTE_SECOND);
    wr(wdog_pkg::SERVICE_REG_ADDR, wdog_pkg::ARM_BYTE_FIRST);
    wr(wdog_pkg::SERVICE_REG_ADDR, 8'h55);
    wr(wdog_pkg::SERVICE_REG_ADDR, wdog_pkg::ARM_BYTE_SECOND);
    `CHK(hwArmed, 1'b0, "armed by broken sequence")
    wr(wdog_pkg::SERVICE_REG_ADDR, wdog_pkg::ARM_BYTE_FIRST);
    `CHK(hwArmed, 1'b0, "armed too early")
    wr(wdog_pkg::SERVICE_REG_ADDR, wdog_pkg::ARM_BYTE_SECOND);
    `CHK(hwArmed, 1'b1, "not armed after sequence")
    @(negedge ref_clk);
    `CHK(hwArmed, 1'b1, "not armed after sequence")
    wr(wdog_pkg::SERVICE_REG_ADDR, 8'h00);
    wr(wdog_pkg::SERVICE_REG_ADDR, 8'hff);
    `CHK(hwArmed, 1'b1, "disarmed by software")
    rstn = 1'b0;
    @(negedge ref_clk);
    rstn = 1'b1;
    `CHK(hwArmed, 1'b0, "armed across reset")
    $display("test arming done");
    wr(wdog_pkg::SERVICE_REG_ADDR, wdog_pkg::ARM_BYTE_FIRST);
    wr(wdog_pkg::SERVICE_REG_ADDR, wdog_pkg::ARM_BYTE_SECOND);
    repeat (600) @(negedge ref_clk);
    // Service late: an unrestarted count would fire 600 cycles early
    wr(wdog_pkg::SERVICE_REG_ADDR, wdog_pkg::ARM_BYTE_FIRST);
    wr(wdog_pkg::SERVICE_REG_ADDR, wdog_pkg::ARM_BYTE_SECOND);
    n = 2;
    while (internalReset !== 1'b1 && n < 99000) begin @(negedge ref_clk); n++; end
    if (n >= 99000) begin fails++; results(); end
    `CHK(n inside {[16383 * 6 - 16 : 16383 * 6 + 16]}, 1'b1, "overflow time")
    @(negedge ref_clk);
    `CHK({internalReset, resetPinOut}, 2'b01, "reset pulse start")
    n = 0;
    while (resetPinOut === 1'b1 && n < 300) begin n++; @(negedge ref_clk); end
    `CHK(n, wdog_pkg::PULSE_OSC_SIX, "reset pin pulse length")
    `CHK(hwArmed, 1'b0, "armed after overflow reset")
    $display("test overflow done");
    results();
  end
endmodule
`default_nettype wire
